/* File: src/rhda_defines.svh */
`ifndef RHDA_DEFINES_SVH
`define RHDA_DEFINES_SVH

// Register byte addresses within the block.
`define RHDA_DESC_OFFSET    8'h48
`define RHDA_STAT_OFFSET    8'h80

// Descriptor field positions.
`define RHDA_PGD_MSB        25
`define RHDA_PGD_LSB        24
`define RHDA_PGD_TOP        31
`define RHDA_RSVD_MSB       23
`define RHDA_RSVD_LSB       13
`define RHDA_NO_OC_BIT      12
`define RHDA_OCM_BIT        11
`define RHDA_COMPOUND_BIT   10
`define RHDA_NO_SW_BIT      9
`define RHDA_PSM_BIT        8
`define RHDA_PORTS_MSB      7
`define RHDA_PORTS_LSB      0

// Byte lanes that carry the writable fields.
`define RHDA_PGD_LANE       3
`define RHDA_CFG_LANE       1

// Status field positions.
`define RHDA_STAT_GOOD_BIT  0
`define RHDA_STAT_BUSY_BIT  1

// Reset values.
`define RHDA_PGD_RST        2'h1
`define RHDA_NO_OC_RST      1'b0
`define RHDA_OCM_RST        1'b0
`define RHDA_NO_SW_RST      1'b0
`define RHDA_PSM_RST        1'b0
`define RHDA_COMPOUND_VAL   1'b0
`define RHDA_PORTS_RST      2

// Timing.
`define RHDA_INTERVAL_NS    2000000
`define RHDA_CLK_NS         20

// Bus responses.
`define RHDA_RESP_OKAY      2'h0
`define RHDA_RESP_SLVERR    2'h2

`endif

/* File: src/rhda_pkg.sv */
package rhda_pkg;

    // Writable descriptor fields.
    typedef struct packed {
        logic [1:0] pgd;
        logic       no_oc;
        logic       ocm;
        logic       no_sw;
        logic       psm;
    } rhda_desc_t;

    // Port power sequencing state, Gray coded along idle, count, good.
    typedef enum logic [1:0] {
        RHDA_IDLE  = 2'h0,
        RHDA_COUNT = 2'h1,
        RHDA_GOOD  = 2'h3
    } rhda_state_t;

endpackage

/* File: src/rhda_top.sv */
// Behaviour
// RQ1: Power-good delay field counts 2 ms intervals before switched port power is good.
// RQ2: Only bits 25:24 of the delay field store; bits 31:26 read zero.
// RQ3: Software programs the delay to one, may adjust it, never zero.
// RQ4: Bits 23:13 are reserved, read zero, written as zero.
// RQ5: Bit 12 set means over-current status is not reported.
// RQ6: Bit 11 picks global or per-port over-current, valid only with bit 12 clear.
// RQ7: Bit 10 reads zero: the root hub is not a compound device.
// RQ8: Bit 9 set means ports are permanently powered, clear means switched.
// RQ9: Bit 8 picks global or per-port switching, effective only with bit 9 clear.
// RQ10: Bits 7:0 report two downstream ports.
// RQ11: Only power-on reset restores the register; software writes it at initialisation.
// RQ12: Writes to fixed or reserved bits are ignored and change nothing.
`include "rhda_defines.svh"

module rhda_top
    import rhda_pkg::*;
#(
    parameter int          ADDR_W          = 8,
    parameter int          INTERVAL_CYCLES = `RHDA_INTERVAL_NS / `RHDA_CLK_NS,
    parameter logic [7:0]  PORT_COUNT      = 8'(`RHDA_PORTS_RST)
) (
    // Clock and power-on reset.
    input  wire logic              clk,
    input  wire logic              rst,
    // AXI4-Lite write address.
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output logic                   s_axi_awready,
    // AXI4-Lite write data.
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output logic                   s_axi_wready,
    // AXI4-Lite write response.
    output logic [1:0]             s_axi_bresp,
    output logic                   s_axi_bvalid,
    input  wire logic              s_axi_bready,
    // AXI4-Lite read address.
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output logic                   s_axi_arready,
    // AXI4-Lite read data.
    output logic [31:0]            s_axi_rdata,
    output logic [1:0]             s_axi_rresp,
    output logic                   s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // Port power requests from the root hub port logic.
    input  wire logic              port_power_on,
    input  wire logic              port_power_off,
    // Settings and power state toward the root hub port logic.
    output logic [1:0]             power_good_delay,
    output logic                   no_overcurrent_report,
    output logic                   overcurrent_report_mode,
    output logic                   no_port_power_switch,
    output logic                   power_switch_mode,
    output logic [7:0]             downstream_port_count,
    output logic                   port_power_good
);

    localparam int DIV_W = $clog2(INTERVAL_CYCLES + 1);

    if (ADDR_W < 8 || ADDR_W > 32) begin
        $error("ADDR_W must lie between 8 and 32.");
    end
    if (INTERVAL_CYCLES < 1) begin
        $error("INTERVAL_CYCLES must be at least one.");
    end
    if (PORT_COUNT == 8'h00) begin
        $error("PORT_COUNT must be non-zero.");
    end

    function automatic logic hits(input logic [ADDR_W-1:0] addr, input logic [7:0] offset);
        hits = (addr[ADDR_W-1:2] == (ADDR_W-2)'(offset[7:2]));
    endfunction

    rhda_desc_t         desc_reg;
    rhda_state_t        state_reg;
    logic               aw_hold_reg;
    logic [ADDR_W-1:0]  aw_addr_reg;
    logic               w_hold_reg;
    logic [31:0]        w_data_reg;
    logic [3:0]         w_strb_reg;
    logic               aw_hold_next;
    logic               w_hold_next;
    logic               do_write;
    logic               rsel_desc_reg;
    logic [1:0]         intervals_reg;
    logic [1:0]         start_delay_reg;
    logic [DIV_W-1:0]   div_reg;
    logic               tick;
    logic [31:0]        desc_word;
    logic [31:0]        stat_word;
    logic [31:0]        elapsed_reg;

    // Write channel capture, address and data accepted in either order.
    assign do_write     = aw_hold_reg && w_hold_reg && !s_axi_bvalid;
    assign aw_hold_next = do_write ? 1'b0 : (aw_hold_reg || (s_axi_awvalid && s_axi_awready));
    assign w_hold_next  = do_write ? 1'b0 : (w_hold_reg || (s_axi_wvalid && s_axi_wready));

    always_ff @(posedge clk) begin
        if (rst) begin
            aw_hold_reg   <= 1'b0;
            w_hold_reg    <= 1'b0;
            aw_addr_reg   <= '0;
            w_data_reg    <= 32'h0;
            w_strb_reg    <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
        end else begin
            aw_hold_reg   <= aw_hold_next;
            w_hold_reg    <= w_hold_next;
            s_axi_awready <= !aw_hold_next && !(do_write || (s_axi_bvalid && !s_axi_bready));
            s_axi_wready  <= !w_hold_next && !(do_write || (s_axi_bvalid && !s_axi_bready));
            if (s_axi_awvalid && s_axi_awready) begin
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_data_reg <= s_axi_wdata;
                w_strb_reg <= s_axi_wstrb;
            end
        end
    end

    // Write response, one cycle after both halves are held.
    always_ff @(posedge clk) begin
        if (rst) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `RHDA_RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (hits(aw_addr_reg, `RHDA_DESC_OFFSET) || hits(aw_addr_reg, `RHDA_STAT_OFFSET))
                            ? `RHDA_RESP_OKAY : `RHDA_RESP_SLVERR;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Descriptor storage, restored by the power-on reset only.
    always_ff @(posedge clk) begin
        if (rst) begin
            desc_reg.pgd   <= `RHDA_PGD_RST; // RQ11
            desc_reg.no_oc <= `RHDA_NO_OC_RST;
            desc_reg.ocm   <= `RHDA_OCM_RST;
            desc_reg.no_sw <= `RHDA_NO_SW_RST;
            desc_reg.psm   <= `RHDA_PSM_RST;
        end else if (do_write && hits(aw_addr_reg, `RHDA_DESC_OFFSET)) begin
            if (w_strb_reg[`RHDA_PGD_LANE]) begin
                desc_reg.pgd <= w_data_reg[`RHDA_PGD_MSB:`RHDA_PGD_LSB]; // RQ2
            end
            if (w_strb_reg[`RHDA_CFG_LANE]) begin
                desc_reg.no_oc <= w_data_reg[`RHDA_NO_OC_BIT]; // RQ5
                desc_reg.ocm   <= w_data_reg[`RHDA_OCM_BIT]; // RQ6
                desc_reg.no_sw <= w_data_reg[`RHDA_NO_SW_BIT]; // RQ8
                desc_reg.psm   <= w_data_reg[`RHDA_PSM_BIT]; // RQ9
            end
        end
    end

    // Read words; every unlisted bit is a constant zero.
    always_comb begin
        desc_word = 32'h0; // RQ4 RQ12
        desc_word[`RHDA_PGD_MSB:`RHDA_PGD_LSB] = desc_reg.pgd; // RQ2
        desc_word[`RHDA_NO_OC_BIT] = desc_reg.no_oc;
        desc_word[`RHDA_OCM_BIT] = desc_reg.ocm;
        desc_word[`RHDA_COMPOUND_BIT] = `RHDA_COMPOUND_VAL; // RQ7
        desc_word[`RHDA_NO_SW_BIT] = desc_reg.no_sw;
        desc_word[`RHDA_PSM_BIT] = desc_reg.psm;
        desc_word[`RHDA_PORTS_MSB:`RHDA_PORTS_LSB] = PORT_COUNT; // RQ10
        stat_word = 32'h0;
        stat_word[`RHDA_STAT_GOOD_BIT] = (state_reg == RHDA_GOOD);
        stat_word[`RHDA_STAT_BUSY_BIT] = (state_reg == RHDA_COUNT);
    end

    // Read channel, data one cycle after the address is taken.
    always_ff @(posedge clk) begin
        if (rst) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0;
            s_axi_rresp   <= `RHDA_RESP_OKAY;
            rsel_desc_reg <= 1'b0;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            rsel_desc_reg <= hits(s_axi_araddr, `RHDA_DESC_OFFSET);
            if (hits(s_axi_araddr, `RHDA_DESC_OFFSET)) begin
                s_axi_rdata <= desc_word;
                s_axi_rresp <= `RHDA_RESP_OKAY;
            end else if (hits(s_axi_araddr, `RHDA_STAT_OFFSET)) begin
                s_axi_rdata <= stat_word;
                s_axi_rresp <= `RHDA_RESP_OKAY;
            end else begin
                s_axi_rdata <= 32'h0;
                s_axi_rresp <= `RHDA_RESP_SLVERR;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end else if (!s_axi_rvalid) begin
            s_axi_arready <= 1'b1;
        end
    end

    // Settings toward the port logic; mode bits count only when their disable bit is clear.
    always_ff @(posedge clk) begin
        if (rst) begin
            power_good_delay        <= `RHDA_PGD_RST;
            no_overcurrent_report   <= `RHDA_NO_OC_RST;
            overcurrent_report_mode <= `RHDA_OCM_RST;
            no_port_power_switch    <= `RHDA_NO_SW_RST;
            power_switch_mode       <= `RHDA_PSM_RST;
            downstream_port_count   <= PORT_COUNT;
        end else begin
            power_good_delay        <= desc_reg.pgd;
            no_overcurrent_report   <= desc_reg.no_oc; // RQ5
            overcurrent_report_mode <= desc_reg.ocm && !desc_reg.no_oc; // RQ6
            no_port_power_switch    <= desc_reg.no_sw; // RQ8
            power_switch_mode       <= desc_reg.psm && !desc_reg.no_sw; // RQ9
            downstream_port_count   <= PORT_COUNT; // RQ10
        end
    end

    // Interval divider, one pulse per 2 ms while counting.
    assign tick = (div_reg == DIV_W'(INTERVAL_CYCLES - 1));

    always_ff @(posedge clk) begin
        if (rst || state_reg != RHDA_COUNT || tick) begin
            div_reg <= '0;
        end else begin
            div_reg <= div_reg + 1'b1;
        end
    end

    // Power sequencing: switched ports become good after the programmed intervals.
    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg       <= RHDA_IDLE;
            intervals_reg   <= 2'h0;
            start_delay_reg <= 2'h0;
        end else if (desc_reg.no_sw) begin
            state_reg <= RHDA_GOOD; // RQ8
        end else if (port_power_off) begin
            state_reg <= RHDA_IDLE;
        end else begin
            case (state_reg)
                RHDA_IDLE: begin
                    if (port_power_on) begin
                        intervals_reg   <= desc_reg.pgd; // RQ1
                        start_delay_reg <= desc_reg.pgd;
                        state_reg       <= (desc_reg.pgd == 2'h0) ? RHDA_GOOD : RHDA_COUNT;
                    end
                end
                RHDA_COUNT: begin
                    if (tick) begin
                        intervals_reg <= intervals_reg - 2'h1; // RQ1
                        if (intervals_reg == 2'h1) begin
                            state_reg <= RHDA_GOOD;
                        end
                    end
                end
                RHDA_GOOD: begin
                    state_reg <= RHDA_GOOD;
                end
                default: begin
                    state_reg <= RHDA_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            port_power_good <= 1'b0;
        end else begin
            port_power_good <= (state_reg == RHDA_GOOD);
        end
    end

    // Cycles spent counting, read only by the timing check.
    always_ff @(posedge clk) begin
        if (rst || state_reg != RHDA_COUNT) begin
            elapsed_reg <= 32'h0;
        end else begin
            elapsed_reg <= elapsed_reg + 32'h1;
        end
    end

    timing_exact_a: assert property (@(posedge clk) disable iff (rst) // RQ1
        (state_reg == RHDA_COUNT && tick && intervals_reg == 2'h1 && !port_power_off && !desc_reg.no_sw)
        |-> (elapsed_reg + 32'h1 == 32'(start_delay_reg) * 32'(INTERVAL_CYCLES)))
        else $error("Power good reached after the wrong number of cycles.");

    delay_store_a: assert property (@(posedge clk) disable iff (rst) // RQ2
        (do_write && hits(aw_addr_reg, `RHDA_DESC_OFFSET) && w_strb_reg[`RHDA_PGD_LANE])
        |=> ##1 (power_good_delay == $past(w_data_reg[`RHDA_PGD_MSB:`RHDA_PGD_LSB], 2)))
        else $error("Delay field did not take the written value.");

    reserved_zero_a: assert property (@(posedge clk) disable iff (rst) // RQ4
        (s_axi_rvalid && rsel_desc_reg)
        |-> (s_axi_rdata[`RHDA_PGD_TOP:`RHDA_PGD_MSB + 1] == '0
             && s_axi_rdata[`RHDA_RSVD_MSB:`RHDA_RSVD_LSB] == '0 && !s_axi_rdata[`RHDA_COMPOUND_BIT]))
        else $error("Fixed descriptor bits read non-zero.");

    port_count_a: assert property (@(posedge clk) disable iff (rst) // RQ10
        (s_axi_rvalid && rsel_desc_reg) |-> (s_axi_rdata[`RHDA_PORTS_MSB:`RHDA_PORTS_LSB] == PORT_COUNT))
        else $error("Port count reads wrong.");

    oc_report_a: assert property (@(posedge clk) disable iff (rst) // RQ5
        ##1 (no_overcurrent_report == $past(desc_reg.no_oc)))
        else $error("Over-current report flag does not follow the register.");

    oc_mode_gate_a: assert property (@(posedge clk) disable iff (rst) // RQ6
        overcurrent_report_mode |-> (!no_overcurrent_report && $past(desc_reg.ocm)))
        else $error("Per-port over-current mode active while reporting is off.");

    psw_mode_gate_a: assert property (@(posedge clk) disable iff (rst) // RQ9
        power_switch_mode |-> (!no_port_power_switch && $past(desc_reg.psm)))
        else $error("Per-port switching active while ports are always powered.");

    always_powered_a: assert property (@(posedge clk) disable iff (rst) // RQ8
        desc_reg.no_sw [*3] |-> port_power_good)
        else $error("Permanently powered ports not reported good.");

    write_only_a: assert property (@(posedge clk) disable iff (rst) // RQ11 RQ12
        !do_write |=> $stable(desc_reg))
        else $error("Descriptor changed without a write.");

endmodule

/* File: dv/rhda_top_tb.sv */
`include "rhda_defines.svh"

module rhda_top_tb;
    timeunit 1ns;
    timeprecision 1ps;

    localparam int         IC  = 8;
    localparam logic [7:0] BAD = 8'h10;

    logic        clk;
    logic        rst;
    logic [7:0]  awaddr;
    logic        awvalid;
    logic        awready;
    logic [31:0] wdata;
    logic [3:0]  wstrb;
    logic        wvalid;
    logic        wready;
    logic [1:0]  bresp;
    logic        bvalid;
    logic        bready;
    logic [7:0]  araddr;
    logic        arvalid;
    logic        arready;
    logic [31:0] rdata;
    logic [1:0]  rresp;
    logic        rvalid;
    logic        rready;
    logic        pwr_on;
    logic        pwr_off;
    logic [1:0]  pgd;
    logic        no_oc;
    logic        ocm;
    logic        no_sw;
    logic        psm;
    logic [7:0]  ports;
    logic        good;
    int          err_count;
    int          tests_run;
    int          n;

    rhda_top #(.INTERVAL_CYCLES(IC)) rhda_top_i (
        .clk(clk), .rst(rst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
        .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .port_power_on(pwr_on), .port_power_off(pwr_off),
        .power_good_delay(pgd), .no_overcurrent_report(no_oc), .overcurrent_report_mode(ocm),
        .no_port_power_switch(no_sw), .power_switch_mode(psm), .downstream_port_count(ports),
        .port_power_good(good)
    );

    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    task automatic end_of_test();
        $display("checks %0d mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic check(input string name, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            $display("wrong value %s expected %h seen %h", name, exp, got);
            err_count++;
        end
    endtask

    // Address and data are offered together; bready and rready stay high.
    // Handshakes are judged on values settled at the falling edge before each rising edge.
    task automatic axi_write(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
                             input logic [1:0] er);
        int         i;
        logic       aw_hs;
        logic       w_hs;
        logic       b_seen;
        logic [1:0] b_resp;
        b_seen  = 1'b0;
        b_resp  = 2'h0;
        awaddr  <= a;
        wdata   <= d;
        wstrb   <= s;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(negedge clk);
            aw_hs  = awvalid && awready;
            w_hs   = wvalid && wready;
            b_seen = (bvalid === 1'b1);
            b_resp = bresp;
            @(posedge clk);
            if (aw_hs) awvalid <= 1'b0;
            if (w_hs) wvalid <= 1'b0;
            if (b_seen) break;
        end
        if (i == 50) begin
            err_count++;
            end_of_test();
        end
        check("bresp", 32'(er), 32'(b_resp));
    endtask

    task automatic axi_read(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
        int          i;
        logic        ar_hs;
        logic        r_seen;
        logic [31:0] r_data;
        logic [1:0]  r_resp;
        r_seen  = 1'b0;
        r_data  = 32'h0;
        r_resp  = 2'h0;
        araddr  <= a;
        arvalid <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(negedge clk);
            ar_hs  = arvalid && arready;
            r_seen = (rvalid === 1'b1);
            r_data = rdata;
            r_resp = rresp;
            @(posedge clk);
            if (ar_hs) arvalid <= 1'b0;
            if (r_seen) break;
        end
        if (i == 50) begin
            err_count++;
            end_of_test();
        end
        check("rresp", 32'(er), 32'(r_resp));
        check("rdata", ed, r_data);
    endtask

    initial begin
        err_count = 0;
        tests_run = 0;
        rst = 1'b1;
        awaddr = 8'h00;
        awvalid = 1'b0;
        wdata = 32'h0;
        wstrb = 4'h0;
        wvalid = 1'b0;
        bready = 1'b1;
        araddr = 8'h00;
        arvalid = 1'b0;
        rready = 1'b1;
        pwr_on = 1'b0;
        pwr_off = 1'b0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        repeat (2) @(posedge clk);
        check("delay out", 32'h1, 32'(pgd));
        check("port count", 32'h2, 32'(ports));
        axi_read(`RHDA_DESC_OFFSET, 32'h0100_0002, 2'h0);
        axi_write(`RHDA_DESC_OFFSET, 32'hFFFF_FFFF, 4'hF, 2'h0);
        axi_read(`RHDA_DESC_OFFSET, 32'h0300_1B02, 2'h0);
        repeat (2) @(posedge clk);
        check("delay out", 32'h3, 32'(pgd));
        check("no_oc out", 32'h1, 32'(no_oc));
        check("ocm out", 32'h0, 32'(ocm));
        check("no_sw out", 32'h1, 32'(no_sw));
        check("psm out", 32'h0, 32'(psm));
        // Lanes 0 and 2 carry no writable field, so nothing may move.
        axi_write(`RHDA_DESC_OFFSET, 32'hFFFF_FFFF, 4'h5, 2'h0);
        axi_read(`RHDA_DESC_OFFSET, 32'h0300_1B02, 2'h0);
        axi_write(`RHDA_DESC_OFFSET, 32'h0000_0900, 4'h2, 2'h0);
        axi_write(`RHDA_DESC_OFFSET, 32'h0200_0000, 4'h8, 2'h0);
        axi_read(`RHDA_DESC_OFFSET, 32'h0200_0902, 2'h0);
        repeat (2) @(posedge clk);
        check("ocm out", 32'h1, 32'(ocm));
        check("psm out", 32'h1, 32'(psm));
        check("no_oc out", 32'h0, 32'(no_oc));
        check("no_sw out", 32'h0, 32'(no_sw));
        // The good state forced earlier is left by a power-off before sequencing starts.
        pwr_off <= 1'b1;
        @(posedge clk);
        pwr_off <= 1'b0;
        pwr_on  <= 1'b1;
        @(posedge clk);
        pwr_on  <= 1'b0;
        // Good is sampled at falling edges and rises one edge after the last interval ends.
        for (n = 0; n < 200; n++) begin
            @(negedge clk);
            if (good === 1'b1) break;
        end
        check("good delay", 32'(2 * IC + 1), 32'(n));
        if (n == 200) end_of_test();
        @(posedge clk);
        axi_read(`RHDA_STAT_OFFSET, 32'h0000_0001, 2'h0);
        pwr_off <= 1'b1;
        @(posedge clk);
        pwr_off <= 1'b0;
        repeat (3) @(posedge clk);
        check("good off", 32'h0, 32'(good));
        axi_write(`RHDA_DESC_OFFSET, 32'h0000_0200, 4'h2, 2'h0);
        repeat (3) @(posedge clk);
        check("good fixed", 32'h1, 32'(good));
        axi_write(BAD, 32'hFFFF_FFFF, 4'hF, 2'h2);
        axi_read(BAD, 32'h0, 2'h2);
        axi_read(`RHDA_DESC_OFFSET, 32'h0200_0202, 2'h0);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        axi_read(`RHDA_DESC_OFFSET, 32'h0100_0002, 2'h0);
        end_of_test();
    end
endmodule
